// ==== core/sbxa_pkg.sv ====
// shared constants and types for the expansion socket adapter
`default_nettype none
package sbxa_pkg;
  // address decode field positions
  localparam int unsigned WIN_LSB = 5;
  localparam int unsigned WIN_MSB = 7;
  localparam int unsigned BLK_BIT = 4;
  localparam int unsigned PORT_MSB = 3;
  localparam int unsigned CASC_LSB = 8;
  localparam int unsigned CASC_MSB = 10;
  // interrupt controller sizing
  localparam int unsigned NUM_IRQ = 8;
  localparam int unsigned NUM_MOD_IRQ = 4;
  // control port register offsets (address bit 0)
  localparam logic CTL_REG_VBASE = 1'h0;
  localparam logic CTL_REG_MASK = 1'h1;
  // reset values
  localparam logic [7:0] VBASE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // lines usable per variant
  localparam logic [7:0] CTC_LINES = 8'h0F;
  localparam logic [7:0] PIC_LINES = 8'hFF;
  // build strap codes
  localparam logic [1:0] STRAP_CTC = 2'h1;
  localparam logic [1:0] STRAP_PIC = 2'h2;

  typedef enum logic [1:0] {VAR_NONE, VAR_CTC, VAR_PIC} sbxa_variant_t;

  // every pin input that is brought through the synchroniser
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] d;
    logic iorq_n;
    logic rd_n;
    logic wr_n;
    logic inta_n;
    logic ioexp;
    logic pri_in_n;
    logic [7:0] md;
    logic [3:0] mint;
    logic [3:0] xint;
    logic [2:0] base0;
    logic [2:0] base1;
    logic [2:0] ctlb;
    logic ioexp_req;
  } sbxa_pins_t;
endpackage : sbxa_pkg
`default_nettype wire

// ==== core/sbxa_if.sv ====
// link between the decode logic and the interrupt controller
`default_nettype none
interface sbxa_if;
  sbxa_pkg::sbxa_variant_t variant;
  logic [7:0] irq;
  logic wr_vbase;
  logic wr_mask;
  logic [7:0] wdata;
  logic ack;
  logic req;
  logic [7:0] vec;
  logic [2:0] casc;
  logic [7:0] pend;
  logic [7:0] mask;

  modport dec (output variant, irq, wr_vbase, wr_mask, wdata, ack,
               input req, vec, casc, pend, mask);
  modport ctl (input variant, irq, wr_vbase, wr_mask, wdata, ack,
               output req, vec, casc, pend, mask);
endinterface : sbxa_if
`default_nettype wire

// ==== core/sbxa_intc.sv ====
// on-board priority interrupt controller, counter-timer or priority build
`default_nettype none
module sbxa_intc (
  // clocking
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // decode side
  sbxa_if.ctl bus
);
  typedef struct packed {
    logic [7:0] irq_prev;
    logic [7:0] pend;
    logic [7:0] mask;
    logic [7:0] vbase;
    logic [7:0] vec;
    logic [2:0] casc;
    logic req;
  } sbxa_intc_st_t;

  sbxa_intc_st_t q, d;

  // next state: edge capture, priority pick, vector latch
  always_comb
  begin
    logic [7:0] lines;
    logic [7:0] live;
    logic [7:0] clr;
    logic [2:0] win;
    logic found;
    lines = 8'h00;
    live = 8'h00;
    clr = 8'h00;
    win = 3'h0;
    found = 1'b0;
    d = q;
    // which inputs exist in this build
    case (bus.variant)
      sbxa_pkg::VAR_CTC: lines = sbxa_pkg::CTC_LINES;
      sbxa_pkg::VAR_PIC: lines = sbxa_pkg::PIC_LINES;
      default: lines = 8'h00;
    endcase
    d.irq_prev = bus.irq;
    live = q.pend & q.mask;
    // lowest index wins
    for (int i = 0; i < sbxa_pkg::NUM_IRQ; i++)
    begin
      if (live[i] && !found)
      begin
        found = 1'b1;
        win = 3'(i);
      end
    end
    if (bus.ack && found)
    begin
      clr[win] = 1'b1;
      d.casc = win;
      if (bus.variant == sbxa_pkg::VAR_CTC)
        d.vec = {q.vbase[7:3], win[1:0], 1'b0};
      else
        d.vec = {q.vbase[7:3], win};
    end
    // a new edge in the clearing cycle is kept: set wins
    d.pend = ((q.pend & ~clr) | (bus.irq & ~q.irq_prev)) & lines;
    if (bus.wr_vbase)
      d.vbase = bus.wdata;
    // nothing is enabled until software programs the mask
    if (bus.wr_mask)
      d.mask = bus.wdata;
    d.req = |(d.pend & d.mask & lines);
  end

  // state register, frozen while ce is low
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.mask <= sbxa_pkg::MASK_RST;
      q.vbase <= sbxa_pkg::VBASE_RST;
    end
    else if (ce)
      q <= d;
  end

  assign bus.req = q.req;
  assign bus.vec = q.vec;
  assign bus.casc = q.casc;
  assign bus.pend = q.pend;
  assign bus.mask = q.mask;
endmodule : sbxa_intc
`default_nettype wire

// ==== core/sbxa_top.sv ====
// host bus to two 8-bit module sockets adapter, top level
// Overview of operation
// - each socket window is a jumpered base aligned on 32 ports, only it decodes
// - address bit 4 splits each socket window into two 16-port chip selects
// - expansion line either ignored or must be low, chosen by jumper
// - no DMA or wait requests are passed; nobody may rely on them
// - one byte moves per bus cycle between host and addressed module
// - priority build gives 8 prioritised inputs each with own vector
// - both interrupt lines of each socket feed separate controller inputs
// - remaining four controller inputs come from an external header
// - parallel priority chain in and out across front-plane cards
// - cascade address on host A8-A10 during acknowledge, priority build only
// - counter-timer build: module interrupt lines drive four trigger inputs
// - an active trigger raises a vectored interrupt only once software sets its mask bit
// - no-interrupt build: no controller, module lines raise nothing
`default_nettype none
module sbxa_top (
  // clocking
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // host bus
  input wire logic [15:0] host_addr_i,
  input wire logic [7:0] host_d_i,
  output logic [7:0] host_d_o,
  output logic host_d_oe,
  input wire logic host_iorq_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_inta_n,
  input wire logic host_ioexp,
  output logic [2:0] host_casc_o,
  output logic host_casc_oe,
  output logic host_intrq_n,
  // front-plane priority chain
  input wire logic pri_in_n,
  output logic pri_out_n,
  // jumpers and build strap
  input wire logic [2:0] jmp_base0,
  input wire logic [2:0] jmp_base1,
  input wire logic [2:0] jmp_ctl_base,
  input wire logic jmp_ioexp_req,
  input wire logic [1:0] strap_variant,
  // module sockets
  output logic [3:0] mod_addr,
  output logic [3:0] mod_cs_n,
  output logic mod_rd_n,
  output logic mod_wr_n,
  input wire logic [7:0] mod_d_i,
  output logic [7:0] mod_d_o,
  output logic mod_d_oe,
  input wire logic [3:0] mod_int,
  input wire logic [3:0] ext_int
);
  localparam int unsigned PW = $bits(sbxa_pkg::sbxa_pins_t);

  typedef struct packed {
    sbxa_pkg::sbxa_pins_t s1;
    sbxa_pkg::sbxa_pins_t s2;
    sbxa_pkg::sbxa_pins_t s3;
    sbxa_pkg::sbxa_pins_t f;
    logic strap_done;
    sbxa_pkg::sbxa_variant_t variant;
    logic ack_prev;
    logic ack_own;
    logic wr_prev;
    logic [7:0] host_d;
    logic host_doe;
    logic [2:0] casc;
    logic casc_oe;
    logic intrq_n;
    logic pri_out_n;
    logic [3:0] maddr;
    logic [3:0] mcs_n;
    logic mrd_n;
    logic mwr_n;
    logic [7:0] md;
    logic mdoe;
  } sbxa_top_st_t;

  sbxa_top_st_t q, d;
  sbxa_pkg::sbxa_pins_t pins;
  sbxa_if ic ();

  // gather raw pins for the synchroniser
  always_comb
  begin
    pins.addr = host_addr_i;
    pins.d = host_d_i;
    pins.iorq_n = host_iorq_n;
    pins.rd_n = host_rd_n;
    pins.wr_n = host_wr_n;
    pins.inta_n = host_inta_n;
    pins.ioexp = host_ioexp;
    pins.pri_in_n = pri_in_n;
    pins.md = mod_d_i;
    pins.mint = mod_int;
    pins.xint = ext_int;
    pins.base0 = jmp_base0;
    pins.base1 = jmp_base1;
    pins.ctlb = jmp_ctl_base;
    pins.ioexp_req = jmp_ioexp_req;
  end

  // no DMA request or wait line exists on either side of this block
  sbxa_intc u_intc (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .bus(ic.ctl)
  );

  // next state: synchronise, decode, steer data and interrupt acknowledge
  always_comb
  begin
    logic [PW-1:0] diff;
    logic io_rd;
    logic io_wr;
    logic exp_ok;
    logic hit0;
    logic hit1;
    logic hit_ctl;
    logic ack_now;
    logic pri_ok;
    diff = '0;
    io_rd = 1'b0;
    io_wr = 1'b0;
    exp_ok = 1'b0;
    hit0 = 1'b0;
    hit1 = 1'b0;
    hit_ctl = 1'b0;
    ack_now = 1'b0;
    pri_ok = 1'b0;
    d = q;
    // three stages; a change counts once stages two and three agree
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    diff = q.s2 ^ q.s3;
    d.f = sbxa_pkg::sbxa_pins_t'((q.s3 & ~diff) | (q.f & diff));
    // strap is caught once, on the first enabled edge after release
    if (!q.strap_done)
    begin
      d.strap_done = 1'b1;
      if (strap_variant == sbxa_pkg::STRAP_CTC)
        d.variant = sbxa_pkg::VAR_CTC;
      else if (strap_variant == sbxa_pkg::STRAP_PIC)
        d.variant = sbxa_pkg::VAR_PIC;
      else
        d.variant = sbxa_pkg::VAR_NONE;
    end
    // plain I/O cycles exclude acknowledge
    io_rd = !q.f.iorq_n && !q.f.rd_n && q.f.inta_n;
    io_wr = !q.f.iorq_n && !q.f.wr_n && q.f.inta_n;
    exp_ok = q.f.ioexp_req ? !q.f.ioexp : 1'b1;
    // address decode per window
    if (q.f.addr[sbxa_pkg::WIN_MSB:sbxa_pkg::WIN_LSB] == q.f.base0)
      hit0 = exp_ok;
    else if (q.f.addr[sbxa_pkg::WIN_MSB:sbxa_pkg::WIN_LSB] == q.f.base1)
      hit1 = exp_ok;
    else if (q.f.addr[sbxa_pkg::WIN_MSB:sbxa_pkg::WIN_LSB] == q.f.ctlb)
      hit_ctl = exp_ok && (q.variant != sbxa_pkg::VAR_NONE);
    // socket strobes, chip select per 16-port block
    d.mcs_n = 4'hF;
    if (io_rd || io_wr)
    begin
      if (hit0)
        d.mcs_n[{1'b0, q.f.addr[sbxa_pkg::BLK_BIT]}] = 1'b0;
      if (hit1)
        d.mcs_n[{1'b1, q.f.addr[sbxa_pkg::BLK_BIT]}] = 1'b0;
    end
    d.maddr = q.f.addr[sbxa_pkg::PORT_MSB:0];
    d.mrd_n = !(io_rd && (hit0 || hit1));
    d.mwr_n = !(io_wr && (hit0 || hit1));
    // one byte toward the module on write
    d.md = q.f.d;
    d.mdoe = io_wr && (hit0 || hit1);
    // controller register writes, one pulse per write cycle
    d.wr_prev = io_wr && hit_ctl;
    ic.wr_vbase = io_wr && hit_ctl && !q.wr_prev
                  && (q.f.addr[0] == sbxa_pkg::CTL_REG_VBASE);
    ic.wr_mask = io_wr && hit_ctl && !q.wr_prev
                 && (q.f.addr[0] == sbxa_pkg::CTL_REG_MASK);
    ic.wdata = q.f.d;
    ic.variant = q.variant;
    // module lines on the low four inputs, header on the high four
    ic.irq = {q.f.xint, q.f.mint};
    // front-plane chain: request and answer only when enabled from above
    pri_ok = !q.f.pri_in_n;
    d.pri_out_n = q.f.pri_in_n || ic.req;
    d.intrq_n = !(ic.req && pri_ok);
    ack_now = !q.f.inta_n && !q.f.rd_n;
    d.ack_prev = ack_now;
    ic.ack = ack_now && !q.ack_prev && pri_ok && ic.req;
    if (!ack_now)
      d.ack_own = 1'b0;
    else if (ic.ack)
      d.ack_own = 1'b1;
    // host data: module byte, controller status or vector
    d.host_doe = 1'b0;
    d.host_d = 8'h00;
    d.casc_oe = 1'b0;
    d.casc = ic.casc;
    if (q.ack_own && ack_now)
    begin
      d.host_doe = 1'b1;
      d.host_d = ic.vec;
      d.casc_oe = (q.variant == sbxa_pkg::VAR_PIC);
    end
    else if (io_rd && (hit0 || hit1))
    begin
      d.host_doe = 1'b1;
      d.host_d = q.f.md;
    end
    else if (io_rd && hit_ctl)
    begin
      d.host_doe = 1'b1;
      if (q.f.addr[0] == sbxa_pkg::CTL_REG_MASK)
        d.host_d = ic.mask;
      else
        d.host_d = ic.pend;
    end
  end

  // state register; idle bus levels are restored on reset
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      // sync stages start at idle strobe levels, so no false cycle follows reset
      q.s1.iorq_n <= 1'b1;
      q.s1.rd_n <= 1'b1;
      q.s1.wr_n <= 1'b1;
      q.s1.inta_n <= 1'b1;
      q.s2.iorq_n <= 1'b1;
      q.s2.rd_n <= 1'b1;
      q.s2.wr_n <= 1'b1;
      q.s2.inta_n <= 1'b1;
      q.s3.iorq_n <= 1'b1;
      q.s3.rd_n <= 1'b1;
      q.s3.wr_n <= 1'b1;
      q.s3.inta_n <= 1'b1;
      q.f.iorq_n <= 1'b1;
      q.f.rd_n <= 1'b1;
      q.f.wr_n <= 1'b1;
      q.f.inta_n <= 1'b1;
      q.variant <= sbxa_pkg::VAR_NONE;
      q.intrq_n <= 1'b1;
      q.pri_out_n <= 1'b1;
      q.mcs_n <= 4'hF;
      q.mrd_n <= 1'b1;
      q.mwr_n <= 1'b1;
    end
    else if (ce)
      q <= d;
  end

  // outputs straight from the state register
  assign host_d_o = q.host_d;
  assign host_d_oe = q.host_doe;
  assign host_casc_o = q.casc;
  assign host_casc_oe = q.casc_oe;
  assign host_intrq_n = q.intrq_n;
  assign pri_out_n = q.pri_out_n;
  assign mod_addr = q.maddr;
  assign mod_cs_n = q.mcs_n;
  assign mod_rd_n = q.mrd_n;
  assign mod_wr_n = q.mwr_n;
  assign mod_d_o = q.md;
  assign mod_d_oe = q.mdoe;
endmodule : sbxa_top
`default_nettype wire

// ==== verif/sbxa_sva.sv ====
// checker for the socket adapter top level
`default_nettype none
module sbxa_sva (
  // clocking
  input wire logic clock,
  input wire logic nrst,
  // host side
  input wire logic [15:0] host_addr_i,
  input wire logic host_ioexp,
  input wire logic host_d_oe,
  input wire logic host_casc_oe,
  input wire logic jmp_ioexp_req,
  // socket side
  input wire logic [3:0] mod_addr,
  input wire logic [3:0] mod_cs_n,
  input wire logic mod_rd_n,
  input wire logic mod_wr_n,
  input wire logic mod_d_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // select start, and select past its first cycle
  sequence sel_on;
    $fell(&mod_cs_n);
  endsequence
  sequence sel_mid;
    !(&mod_cs_n) && !$past(&mod_cs_n);
  endsequence
  a_one_select: assert property ($onehot0(~mod_cs_n))
    else $error("two socket selects at once");
  a_select_strobe: assert property (!(&mod_cs_n) |-> !(mod_rd_n && mod_wr_n))
    else $error("select without a strobe");
  a_strobe_excl: assert property (!(!mod_rd_n && !mod_wr_n))
    else $error("read and write strobes together");
  a_ioexp_gate: assert property (!(&mod_cs_n) && jmp_ioexp_req |-> !$past(host_ioexp, 5))
    else $error("select while expansion line high");
  a_select_hold: assert property (sel_on |=> !(&mod_cs_n) [*5])
    else $error("select dropped early");
  a_addr_follow: assert property (sel_mid |-> mod_addr == $past(host_addr_i[3:0], 5))
    else $error("module address not host address");
  a_write_drive: assert property (!mod_wr_n |-> mod_d_oe && !host_d_oe)
    else $error("write byte not driven to module");
  a_casc_with_vec: assert property (host_casc_oe |-> host_d_oe && (&mod_cs_n))
    else $error("cascade address outside acknowledge");
endmodule : sbxa_sva
bind sbxa_top sbxa_sva u_sva (.clock, .nrst, .host_addr_i, .host_ioexp, .host_d_oe,
  .host_casc_oe, .jmp_ioexp_req, .mod_addr, .mod_cs_n, .mod_rd_n, .mod_wr_n, .mod_d_oe);
`default_nettype wire

// ==== verif/sbxa_host_model.sv ====
// host processor model making bus cycles into the adapter
`default_nettype none
module sbxa_host_model (
  // clocking
  input wire logic clock,
  // bus driven by the host
  output logic [15:0] host_addr_i,
  output logic [7:0] host_d_i,
  output logic host_iorq_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic host_inta_n,
  // read back
  input wire logic [7:0] host_d_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus from time zero
  initial
  begin
    host_addr_i = 16'h0000;
    host_d_i = 8'hFF;
    host_iorq_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_inta_n = 1'b1;
  end
  // fixed length: no wait line exists, so nothing stretches it
  task start(input logic [15:0] a, input logic wr, input logic [7:0] wd, input logic ack);
    @(posedge clock);
    host_addr_i <= a;
    host_d_i <= wd;
    host_iorq_n <= ack;
    host_inta_n <= !ack;
    host_rd_n <= wr;
    host_wr_n <= !wr;
    repeat (14) @(posedge clock);
  endtask : start
  // take the byte; released data shows its inverse, address stays
  task finish(output logic [7:0] q);
    q = host_d_o;
    host_iorq_n <= 1'b1;
    host_rd_n <= 1'b1;
    host_wr_n <= 1'b1;
    host_inta_n <= 1'b1;
    host_d_i <= ~host_d_i;
    repeat (10) @(posedge clock);
  endtask : finish
endmodule : sbxa_host_model
`default_nettype wire

// ==== verif/sbxa_top_tb_top.sv ====
// self-checking bench for the socket adapter
`default_nettype none
module sbxa_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, nrst, ce, host_ioexp, host_d_oe, host_casc_oe, host_intrq_n, pri_out_n;
  logic host_iorq_n, host_rd_n, host_wr_n, host_inta_n, jmp_ioexp_req;
  logic mod_rd_n, mod_wr_n, mod_d_oe, pri_in_n;
  logic [15:0] host_addr_i;
  logic [7:0] host_d_i, host_d_o, mod_d_i, mod_d_o, q;
  logic [3:0] mod_addr, mod_cs_n, mod_int, ext_int;
  logic [2:0] host_casc_o;
  logic [1:0] strap_variant;
  int fail_count, n_checks;
  // decode table: address, expected selects, expansion line, jumper
  localparam logic [15:0] DA [5] = '{16'h0021, 16'h0021, 16'h0080, 16'h001F, 16'h0021};
  localparam logic [3:0] DCS [5] = '{4'hF, 4'hE, 4'hF, 4'hF, 4'hE};
  localparam logic [4:0] DXP = 5'h11;
  localparam logic [4:0] DRQ = 5'h0F;
  sbxa_top dut (.clock, .nrst, .ce, .host_addr_i, .host_d_i, .host_d_o, .host_d_oe,
    .host_iorq_n, .host_rd_n, .host_wr_n, .host_inta_n, .host_ioexp, .host_casc_o,
    .host_casc_oe, .host_intrq_n, .pri_in_n, .pri_out_n, .jmp_base0(3'h1),
    .jmp_base1(3'h2), .jmp_ctl_base(3'h3), .jmp_ioexp_req, .strap_variant, .mod_addr,
    .mod_cs_n, .mod_rd_n, .mod_wr_n, .mod_d_i, .mod_d_o, .mod_d_oe, .mod_int, .ext_int);
  sbxa_host_model host (.clock, .host_addr_i, .host_d_i, .host_iorq_n, .host_rd_n,
    .host_wr_n, .host_inta_n, .host_d_o);
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // unselected module data wanders; a selected one holds its byte
  always @(posedge clock)
    mod_d_i <= (&mod_cs_n) ? ~mod_d_i : 8'hC3;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // strap is sampled just after release, so it is set inside reset
  task do_reset(input logic [1:0] v);
    nrst <= 1'b0;
    strap_variant <= v;
    mod_int <= 4'h0;
    ext_int <= 4'h0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : do_reset
  task t_write;
    host.start(16'h0035, 1'b1, 8'h5A, 1'b0);
    chk(mod_cs_n, 4'hD);
    chk(mod_wr_n, 1'b0);
    chk(mod_d_o, 8'h5A);
    chk(mod_d_oe, 1'b1);
    host.finish(q);
  endtask : t_write
  task t_read;
    host.start(16'h004E, 1'b0, 8'h00, 1'b0);
    chk(mod_cs_n, 4'hB);
    chk(mod_addr, 4'hE);
    chk(mod_rd_n, 1'b0);
    chk(host_d_oe, 1'b1);
    host.finish(q);
    chk(q, 8'hC3);
  endtask : t_read
  task t_decode;
    for (int i = 0; i < 5; i++)
    begin
      host_ioexp <= DXP[i];
      jmp_ioexp_req <= DRQ[i];
      host.start(DA[i], 1'b0, 8'h00, 1'b0);
      chk(mod_cs_n, DCS[i]);
      host.finish(q);
    end
    host_ioexp <= 1'b0;
  endtask : t_decode
  task t_irq;
    int n;
    host.start(16'h0060, 1'b1, 8'hA8, 1'b0);
    host.finish(q);
    host.start(16'h0061, 1'b1, 8'h12, 1'b0);
    host.finish(q);
    host.start(16'h0061, 1'b0, 8'h00, 1'b0);
    host.finish(q);
    chk(q, 8'h12);
    // chain not enabled from above: request held back, passed on blocked
    pri_in_n <= 1'b1;
    mod_int <= 4'h2;
    ext_int <= 4'h1;
    repeat (20) @(posedge clock);
    chk(host_intrq_n, 1'b1);
    chk(pri_out_n, 1'b1);
    pri_in_n <= 1'b0;
    n = 0;
    while (host_intrq_n !== 1'b0 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    chk(host_intrq_n, 1'b0);
    chk(pri_out_n, 1'b1);
    if (n == 50)
      close_out;
    for (int k = 0; k < 2; k++)
    begin
      host.start(16'h0000, 1'b0, 8'h00, 1'b1);
      chk(host_casc_o, k ? 3'h4 : 3'h1);
      chk(host_casc_oe, 1'b1);
      host.finish(q);
      chk(q, k ? 8'hAC : 8'hA9);
    end
    chk(host_intrq_n, 1'b1);
    chk(pri_out_n, 1'b0);
  endtask : t_irq
  // bare build: no request, controller window dead
  task t_none;
    do_reset(2'h0);
    mod_int <= 4'hF;
    host.start(16'h0060, 1'b0, 8'h00, 1'b0);
    chk(host_d_oe, 1'b0);
    chk(host_intrq_n, 1'b1);
    host.finish(q);
  endtask : t_none
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    host_ioexp = 1'b0;
    pri_in_n = 1'b0;
    jmp_ioexp_req = 1'b0;
    strap_variant = 2'h2;
    mod_int = 4'h0;
    ext_int = 4'h0;
    mod_d_i = 8'h00;
    fail_count = 0;
    n_checks = 0;
    do_reset(2'h2);
    t_write;
    t_read;
    t_decode;
    t_irq;
    t_none;
    close_out;
  end
endmodule : sbxa_top_tb_top
`default_nettype wire
